// File: id_readout_pkg.sv
// Shared constants and types for the identity readout block
package id_readout_pkg;

    // Identifier geometry
    localparam int FUSE_W = 64;
    localparam int ID_W = 57;
    localparam int ID_MSB = 63;
    localparam int ID_LSB = 7;
    localparam int ID_TOP = 56;

    // Fixed identifier; value is arbitrary
    localparam logic [63:0] FUSE_VALUE = 64'h0123_4567_89AB_CDEF;

    // Values after reset, and the pad above the captured identity
    localparam logic [56:0] ID_SR_RESET = 57'h000_0000_0000_0000;
    localparam logic [63:0] JTAG_SR_RESET = 64'h0000_0000_0000_0000;
    localparam logic [6:0] JTAG_PAD = 7'h00;

    // Tap stream buffer shape
    localparam int BUF_W = 2;
    localparam int BUF_DEPTH = 2;

    // User port controls, same clock as the block
    typedef struct packed {
        logic load;
        logic shift;
        logic din;
    } port_ctrl_type;

    // Test access signals arriving from pins
    typedef struct packed {
        logic tck;
        logic tdi;
        logic capture_dr;
        logic shift_dr;
        logic ir_identity;
        logic ir_full;
        logic isc_enabled;
    } jtag_pins_type;

    // One entry of the tap stream
    typedef struct packed {
        logic from_load;
        logic bit_value;
    } tap_bit_type;

    // Selected data register on the test path
    typedef enum logic [2:0] {
        MODE_IDLE = 3'b001,
        MODE_IDENT = 3'b010,
        MODE_FULL = 3'b100
    } jtag_mode_type;

endpackage

// File: id_readout.sv
// Identity readout: user shift port, tap stream buffer, test path register
// Behaviour
// RL1: The identity value is bits 63 down to 7 of the 64-bit identifier.
// RL2: The identifier is a fixed constant that no logic can alter.
// RL3: A load on a clock edge fills the shift register and shows bit 56.
// RL4: Load and shift together perform the load and ignore the shift.
// RL5: Shift without load moves one place out and takes din into bit 0.
// RL6: With neither control high the register and dout hold still.
// RL7: User logic sees the identity only through this readout port.
// RL8: User logic may change din between shifts; each shift takes its current value into bit 0.
// RL9: User logic may feed dout back to din for a circular shift.
// RL10: The test controller enters in-system configuration before reading.
// RL11: The identity read shows bit 56 on tdo on entering Shift-DR.
// RL12: In Shift-DR the remaining bits leave one per tck, then tdi data.
// RL13: The full read sends all 64 identifier bits, bit 0 first.
// RL14: Controls are sampled only on rising clock edges.
`timescale 1ns/1ps

// Two-entry style buffer; depth and width shape the storage
module bit_buffer #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 2
) (
    input wire logic clock, // System clock
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic in_valid, // Producer offers a word
    output logic in_ready, // Buffer has room
    input wire logic [WIDTH-1:0] in_data, // Offered word
    output logic out_valid, // Buffer holds a word
    input wire logic out_ready, // Consumer takes the word
    output logic [WIDTH-1:0] out_data // Oldest word
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // Honest flags straight from the occupancy count
    assign in_ready = count_reg != CW'(DEPTH);
    assign out_valid = count_reg != '0;
    assign out_data = mem_reg[rd_reg];
    assign count_next = count_reg + CW'(push) - CW'(pop);

    // Pointers and count
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wr_reg <= '0;
            rd_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) wr_reg <= bump(wr_reg);
            if (pop) rd_reg <= bump(rd_reg);
            count_reg <= count_next;
        end
    end

    // Storage needs no reset; out_valid guards stale entries
    always_ff @(posedge clock) begin
        if (push) mem_reg[wr_reg] <= in_data;
    end
endmodule

module id_readout (
    input wire logic clock, // 100 MHz system clock
    input wire logic resetn, // Asynchronous reset, active low
    input wire id_readout_pkg::port_ctrl_type port_ctrl, // Load, shift, din
    output logic dout, // Serial identity output
    output logic step_ready, // Tap stream can take another step
    output logic tap_valid, // Tap stream word present
    input wire logic tap_ready, // Tap stream consumer ready
    output id_readout_pkg::tap_bit_type tap_data, // Tap stream word
    input wire id_readout_pkg::jtag_pins_type jtag_pins, // Test pins
    output logic tdo, // Test data out
    output logic tdo_oe // High while tdo is driven
);
    // Identity comes only from the fixed constant
    wire [56:0] id_value =
        id_readout_pkg::FUSE_VALUE[id_readout_pkg::ID_MSB:
                                   id_readout_pkg::ID_LSB]; // see RL1 RL2

    logic [56:0] sr_reg;
    logic [56:0] sr_next;
    id_readout_pkg::tap_bit_type push_word;

    // Load wins over shift; no request means hold
    wire do_load = port_ctrl.load; // see RL4
    wire do_shift = port_ctrl.shift & ~port_ctrl.load;
    assign sr_next = do_load ? id_value : // see RL3
                     do_shift ? {sr_reg[55:0], port_ctrl.din} : // see RL5
                     sr_reg; // see RL6
    assign dout = sr_reg[id_readout_pkg::ID_TOP]; // see RL7

    // Port register, steps only on rising edges
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) sr_reg <= id_readout_pkg::ID_SR_RESET;
        else sr_reg <= sr_next; // see RL14
    end

    // Every step also reports the new dout; a full buffer drops the
    // report, so callers keep steps back while step_ready is low
    assign push_word.from_load = do_load;
    assign push_word.bit_value = sr_next[id_readout_pkg::ID_TOP];

    bit_buffer #(
        .WIDTH(id_readout_pkg::BUF_W),
        .DEPTH(id_readout_pkg::BUF_DEPTH)
    ) tap_buffer (
        .clock(clock),
        .resetn(resetn),
        .in_valid(do_load | do_shift),
        .in_ready(step_ready),
        .in_data(push_word),
        .out_valid(tap_valid),
        .out_ready(tap_ready),
        .out_data(tap_data)
    );

    // Test pins are asynchronous: two flops before anything reads them
    id_readout_pkg::jtag_pins_type sync1_reg;
    id_readout_pkg::jtag_pins_type sync2_reg;
    logic tck_prev_reg;
    id_readout_pkg::jtag_mode_type mode_reg;
    id_readout_pkg::jtag_mode_type mode_next;
    logic [63:0] jsr_reg;
    logic [63:0] jsr_next;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            tck_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= jtag_pins;
            sync2_reg <= sync1_reg;
            tck_prev_reg <= sync2_reg.tck;
        end
    end

    // Edge and state decode on the resynchronised copy only
    wire tck_rise = sync2_reg.tck & ~tck_prev_reg;
    wire capture = tck_rise & sync2_reg.capture_dr;
    wire shifting = tck_rise & sync2_reg.shift_dr;
    wire sel_ident = sync2_reg.isc_enabled & sync2_reg.ir_identity; // see RL10
    wire sel_full = sync2_reg.isc_enabled & sync2_reg.ir_full &
                    ~sync2_reg.ir_identity;

    // Mode chosen at capture; without configuration entry nothing drives
    always_comb begin
        mode_next = mode_reg;
        if (capture) begin
            case (1'b1)
                sel_ident: mode_next = id_readout_pkg::MODE_IDENT;
                sel_full: mode_next = id_readout_pkg::MODE_FULL;
                default: mode_next = id_readout_pkg::MODE_IDLE;
            endcase
        end
    end

    // Identity shifts left to bit 56, full identifier right to bit 0
    always_comb begin
        jsr_next = jsr_reg;
        case (mode_next)
            id_readout_pkg::MODE_IDENT: begin
                if (capture) begin
                    jsr_next = {id_readout_pkg::JTAG_PAD, id_value}; // see RL11
                end else if (shifting) begin
                    jsr_next = {jsr_reg[62:0], sync2_reg.tdi}; // see RL12
                end
            end
            id_readout_pkg::MODE_FULL: begin
                if (capture) begin
                    jsr_next = id_readout_pkg::FUSE_VALUE; // see RL13
                end else if (shifting) begin
                    jsr_next = {sync2_reg.tdi, jsr_reg[63:1]}; // see RL13
                end
            end
            default: jsr_next = jsr_reg;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mode_reg <= id_readout_pkg::MODE_IDLE;
            jsr_reg <= id_readout_pkg::JTAG_SR_RESET;
        end else begin
            mode_reg <= mode_next;
            jsr_reg <= jsr_next;
        end
    end

    // Output bit follows the selected register end
    assign tdo = (mode_reg == id_readout_pkg::MODE_IDENT) ? jsr_reg[56] :
                 (mode_reg == id_readout_pkg::MODE_FULL) ? jsr_reg[0] : 1'b0;
    assign tdo_oe = sync2_reg.shift_dr &
                    (mode_reg != id_readout_pkg::MODE_IDLE);

    property p_load_value;
        @(posedge clock) disable iff (!resetn)
        port_ctrl.load |=> sr_reg == id_readout_pkg::FUSE_VALUE[63:7];
    endproperty
    a_load_value: assert property (p_load_value) // see RL1
        else $error("load did not take identifier bits 63 to 7");

    property p_load_dout;
        @(posedge clock) disable iff (!resetn)
        port_ctrl.load |=> dout == id_readout_pkg::FUSE_VALUE[63];
    endproperty
    a_load_dout: assert property (p_load_dout) // see RL3
        else $error("dout not identity bit 56 after load");

    property p_load_over_shift;
        @(posedge clock) disable iff (!resetn)
        port_ctrl.load && port_ctrl.shift |=> sr_reg == id_value;
    endproperty
    a_load_over_shift: assert property (p_load_over_shift) // see RL4
        else $error("shift was not ignored during load");

    property p_shift_step;
        @(posedge clock) disable iff (!resetn)
        port_ctrl.shift && !port_ctrl.load |=>
            sr_reg == {$past(sr_reg[55:0]), $past(port_ctrl.din)};
    endproperty
    a_shift_step: assert property (p_shift_step) // see RL5
        else $error("shift did not move one place");

    property p_hold;
        @(posedge clock) disable iff (!resetn)
        !port_ctrl.load && !port_ctrl.shift |=> $stable(sr_reg);
    endproperty
    a_hold: assert property (p_hold) // see RL6
        else $error("register changed without a request");

    property p_dout_cause;
        @(posedge clock) disable iff (!resetn)
        $changed(dout) |-> $past(port_ctrl.load | port_ctrl.shift);
    endproperty
    a_dout_cause: assert property (p_dout_cause) // see RL14
        else $error("dout changed without a step");

    property p_ident_first;
        @(posedge clock) disable iff (!resetn)
        capture && sel_ident |=> tdo == id_readout_pkg::FUSE_VALUE[63];
    endproperty
    a_ident_first: assert property (p_ident_first) // see RL11
        else $error("identity read did not start with bit 56");

    property p_ident_shift;
        @(posedge clock) disable iff (!resetn)
        shifting && !capture && mode_reg == id_readout_pkg::MODE_IDENT
            |=> tdo == $past(jsr_reg[55]);
    endproperty
    a_ident_shift: assert property (p_ident_shift) // see RL12
        else $error("identity shift did not advance one bit");

    property p_full_first;
        @(posedge clock) disable iff (!resetn)
        capture && sel_full ##1 (!tck_rise)[*2]
            |-> tdo == id_readout_pkg::FUSE_VALUE[0];
    endproperty
    a_full_first: assert property (p_full_first) // see RL13
        else $error("full read did not start with bit 0");
endmodule

// File: jtag_host.sv
// Test access controller model that drives the tap pins of the block
`timescale 1ns/1ps

module jtag_host (
    input wire logic clock, // System clock, paces the pin changes
    input wire logic tdo, // Test data from the block
    input wire logic tdo_oe, // Block drives tdo
    output id_readout_pkg::jtag_pins_type pins // Pin levels to the block
);
    // Pins idle, tck parked low between frames
    initial begin
        pins = '0;
    end

    // Six clocks per half period clears the three clock sync latency
    task automatic half_tck();
        repeat (6) @(posedge clock);
        #1;
    endtask

    // One data register read of n bits, first bit sampled before any shift
    task automatic read(input logic ident, input logic enter, input int n,
                        output logic [127:0] bits, output logic oe_ok);
        bits = '0;
        oe_ok = 1'b1;
        // Configuration entry comes before the private read
        pins.isc_enabled = enter;
        pins.ir_identity = ident;
        pins.ir_full = !ident;
        pins.tdi = 1'b1;
        half_tck();
        pins.capture_dr = 1'b1;
        half_tck();
        pins.tck = 1'b1;
        half_tck();
        pins.tck = 1'b0;
        pins.capture_dr = 1'b0;
        pins.shift_dr = 1'b1;
        for (int i = 0; i < n; i++) begin
            half_tck();
            bits[i] = tdo;
            if (tdo_oe !== 1'b1) begin
                oe_ok = 1'b0;
            end
            pins.tck = 1'b1;
            half_tck();
            pins.tck = 1'b0;
        end
        pins.shift_dr = 1'b0;
        half_tck();
        // Exit instruction clears the entry and select pins; the user port keeps its state
        pins.isc_enabled = 1'b0;
        pins.ir_identity = 1'b0;
        pins.ir_full = 1'b0;
        // Released tdi shows the inverse of its last level
        pins.tdi = 1'b0;
        // Exit must be seen before a following entry, not a zero-time blip
        half_tck();
    endtask
endmodule

// File: id_readout_bench.sv
// Self-checking bench for the identity readout block
`timescale 1ns/1ps

module id_readout_bench;
    logic clock, resetn, tap_ready, dout, step_ready, tap_valid, tdo, tdo_oe;
    id_readout_pkg::port_ctrl_type port_ctrl;
    id_readout_pkg::tap_bit_type tap_data;
    id_readout_pkg::jtag_pins_type jtag_pins;
    logic [56:0] id_exp;
    logic [127:0] bits;
    logic oe_ok;
    int num_errors, cmp_count, cycles;

    // Expected identity taken from the top of the fixed identifier
    assign id_exp = id_readout_pkg::FUSE_VALUE[63:7];

    id_readout dut (.clock(clock), .resetn(resetn), .port_ctrl(port_ctrl),
        .dout(dout), .step_ready(step_ready), .tap_valid(tap_valid),
        .tap_ready(tap_ready), .tap_data(tap_data), .jtag_pins(jtag_pins),
        .tdo(tdo), .tdo_oe(tdo_oe));

    jtag_host host (.clock(clock), .tdo(tdo), .tdo_oe(tdo_oe),
        .pins(jtag_pins));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // Hang guard, well above the under two thousand cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            $display("[FAIL] %0t timeout", $time);
            wrap_up();
        end
    end

    task automatic chk(input logic got, input logic want, input string what);
        cmp_count++;
        if (got !== want) begin
            num_errors++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask

    // Controls held from just after one edge until just after the next
    task automatic step(input logic ld, input logic sh, input logic di);
        port_ctrl = '{ld, sh, di};
        @(posedge clock);
        #1;
    endtask

    task automatic t_shift_out();
        step(1'b1, 1'b0, 1'b0);
        chk(dout, id_exp[56], "load shows top bit");
        for (int i = 55; i >= 0; i--) begin
            // din held constant through the shift
            step(1'b0, 1'b1, 1'b1);
            chk(dout, id_exp[i], "shift order");
        end
        step(1'b0, 1'b1, 1'b1);
        chk(dout, 1'b1, "din follows identity");
        $display("test shift_out done");
    endtask

    task automatic t_load_wins_hold();
        step(1'b1, 1'b1, 1'b0);
        chk(dout, id_exp[56], "load over shift");
        step(1'b0, 1'b1, 1'b0);
        chk(dout, id_exp[55], "shift after load");
        for (int i = 0; i < 6; i++) begin
            step(1'b0, 1'b0, i[0]);
            chk(dout, id_exp[55], "hold keeps dout");
        end
        $display("test load_wins_hold done");
    endtask

    task automatic t_circular();
        step(1'b1, 1'b0, 1'b0);
        for (int k = 1; k <= 60; k++) begin
            // Output fed back to input
            step(1'b0, 1'b1, dout);
            chk(dout, id_exp[(113 - k) % 57], "circular shift");
        end
        $display("test circular done");
    endtask

    // Receiver stalls: two steps kept, the third report dropped
    task automatic t_buffer();
        // Drain the report of the last earlier step before stalling
        step(1'b0, 1'b0, 1'b0);
        chk(tap_valid, 1'b0, "buffer empty before stall");
        tap_ready = 1'b0;
        step(1'b1, 1'b0, 1'b0);
        step(1'b0, 1'b1, 1'b0);
        step(1'b0, 1'b1, 1'b0);
        step(1'b0, 1'b0, 1'b0);
        chk(step_ready, 1'b0, "buffer full");
        chk(tap_valid, 1'b1, "buffer holds word");
        chk(tap_data.from_load, 1'b1, "first word marks load");
        chk(tap_data.bit_value, id_exp[56], "first word bit");
        tap_ready = 1'b1;
        step(1'b0, 1'b0, 1'b0);
        chk(tap_data.from_load, 1'b0, "second word is a shift");
        chk(tap_data.bit_value, id_exp[55], "second word bit");
        step(1'b0, 1'b0, 1'b0);
        chk(tap_valid, 1'b0, "buffer drained");
        chk(step_ready, 1'b1, "room again");
        $display("test buffer done");
    endtask

    task automatic t_jtag();
        // Read without configuration entry is refused: tdo idle, undriven
        host.read(1'b1, 1'b0, 2, bits, oe_ok);
        chk(oe_ok, 1'b0, "no drive without entry");
        chk(bits[0], 1'b0, "idle tdo low");
        chk(bits[1], 1'b0, "idle tdo stays low");
        host.read(1'b1, 1'b1, 58, bits, oe_ok);
        chk(oe_ok, 1'b1, "tdo driven in shift");
        for (int i = 0; i < 57; i++) begin
            chk(bits[i], id_exp[56 - i], "identity on tdo");
        end
        chk(bits[57], 1'b1, "tdi after identity");
        chk(tdo_oe, 1'b0, "tdo released");
        host.read(1'b0, 1'b1, 65, bits, oe_ok);
        for (int i = 0; i < 64; i++) begin
            chk(bits[i], id_readout_pkg::FUSE_VALUE[i], "full id");
        end
        chk(bits[64], 1'b1, "tdi after full id");
        chk(dout, id_exp[55], "user port untouched");
        $display("test jtag done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        resetn = 1'b0;
        port_ctrl = '0;
        tap_ready = 1'b1;
        repeat (5) @(posedge clock);
        #1;
        chk(dout, 1'b0, "reset dout");
        chk(step_ready, 1'b1, "reset step_ready");
        chk(tap_valid, 1'b0, "reset tap_valid");
        chk(tdo_oe, 1'b0, "reset tdo_oe");
        chk(tdo, 1'b0, "reset tdo");
        resetn = 1'b1;
        @(posedge clock);
        #1;
        t_shift_out();
        t_load_wins_hold();
        t_circular();
        t_buffer();
        step(1'b1, 1'b0, 1'b0);
        step(1'b0, 1'b1, 1'b0);
        step(1'b0, 1'b0, 1'b0);
        t_jtag();
        wrap_up();
    end
endmodule
